/* common/iopm_pkg.sv */
// constants, types and helpers shared by the port pin-function mux
`default_nettype none
package iopm_pkg;

  // ==========================================================
  // port geometry
  localparam int          IOPM_NUM_IO   = 6;     // bidirectional ports 1..6
  localparam int          IOPM_NUM_PORT = 7;     // plus input-only port 7
  localparam int          IOPM_NUM_PU   = 3;     // ports 1..3 carry pull-ups
  localparam int          IOPM_P5_IDX   = 4;     // port 5 sits at index 4
  localparam logic [7:0]  IOPM_P5_MASK  = 8'h07; // port 5 has three pins
  localparam logic [7:0]  IOPM_FULL     = 8'hFF;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_DDR   = 8'h00;     // direction, ports 1..6
  localparam logic [7:0]  OFS_DR    = 8'h08;     // output data, ports 1..6
  localparam logic [7:0]  OFS_PCR   = 8'h10;     // pull-up control, 1..3
  localparam logic [7:0]  OFS_PIN   = 8'h18;     // pin levels, ports 1..7
  localparam logic [7:0]  OFS_CFG   = 8'h20;     // expansion control
  localparam logic [7:0]  OFS_MODE  = 8'h21;     // captured mode, read-only

  // ==========================================================
  // field positions
  localparam int          CFG_EXPANSION_ENABLE_BIT_BIT = 0;      // expansion_enable_bit
  localparam int          CFG_P2IO_BIT = 1;      // port2_upper_pins as port
  localparam int          P1_PWM_X_OUT_0_BIT  = 0;
  localparam int          P1_PWM_X_OUT_1_BIT  = 1;
  localparam int          P2_SDA_BIT   = 3;
  localparam int          P2_SCL_BIT   = 4;
  localparam int          P2_TXD_BIT   = 5;
  localparam int          P2_RXD_BIT   = 6;
  localparam int          P2_SCK_BIT   = 7;
  localparam int          P4_EXT_INTERRUPT_IN_1_BIT  = 1;
  localparam int          P4_EXT_INTERRUPT_IN_0_BIT  = 2;
  localparam int          P4_CLK_BIT   = 6;
  localparam int          P4_IDX       = 3;

  // ==========================================================
  // reset values and mode codes
  localparam logic [7:0]  DDR_RST  = 8'h00;
  localparam logic [7:0]  DR_RST   = 8'h00;
  localparam logic [7:0]  PCR_RST  = 8'h00;
  localparam logic [1:0]  CFG_RST  = 2'h0;
  localparam logic [1:0]  MODE_1   = 2'h1;

  // effective pin-function set
  typedef enum logic [2:0] {
    PM_SINGLE = 3'b001,
    PM_MODE1  = 3'b010,
    PM_EXPAND = 3'b100
  } iopm_pinmode_t;

  // mode 1 always takes its own set PM_MODE1; every other mode follows the enable bit
  function automatic iopm_pinmode_t iopm_pin_mode(input logic [1:0] mode,
                                                  input logic       expansion_enable_bit);
    if (mode == MODE_1) begin
      return PM_MODE1;
    end
    return expansion_enable_bit ? PM_EXPAND : PM_SINGLE;
  endfunction

endpackage
`default_nettype wire

/* common/iopm_cfg_if.sv */
// carrier between the register file and the pin mux
`timescale 1ns/10ps
`default_nettype none
interface iopm_cfg_if;
  logic [5:0][7:0] ddr;   // direction, 1 = output
  logic [5:0][7:0] dr;    // output data
  logic [2:0][7:0] pullup_control_register;   // pull-up enables
  logic            expansion_enable_bit;  // expansion enable
  logic            p2io;  // upper port-2 pins as plain outputs
  logic [1:0]      mode;  // captured operating mode
  logic [6:0][7:0] pin;   // pin levels for readback

  modport regs (output ddr, dr, pullup_control_register, expansion_enable_bit, p2io, mode, input pin);
  modport core (input ddr, dr, pullup_control_register, expansion_enable_bit, p2io, mode, output pin);
endinterface
`default_nettype wire

/* rtl/iopm_regs.sv */
// register file of the port pin-function mux
`timescale 1ns/10ps
`default_nettype none
module iopm_regs
  import iopm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // mode strap
  input  wire logic [1:0] mode_strap,
  // towards the pin mux
  iopm_cfg_if.regs        cfg
);

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input int idx);
    return a == 8'(int'(base) + idx);
  endfunction

  // port 5 keeps only its three real pins
  function automatic logic [7:0] pmask(input int idx);
    return (idx == IOPM_P5_IDX) ? IOPM_P5_MASK : IOPM_FULL;
  endfunction

  logic [5:0][7:0] ddr_ff;
  logic [5:0][7:0] dr_ff;
  logic [2:0][7:0] pcr_ff;
  logic [1:0]      cfg_ff;
  logic [1:0]      mode_ff;
  logic            strap_done_ff;
  logic [7:0]      rdata_ff;
  logic [7:0]      nxt_rdata;

  // ==========================================================
  // mode strap caught on the first edge after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff       <= 2'h0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      mode_ff       <= mode_strap;
      strap_done_ff <= 1'b1;
    end
  end

  // direction registers; clock pin defaults to output in mode 1
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ddr_ff <= {IOPM_NUM_IO{DDR_RST}};
    end else begin
      if (!strap_done_ff) begin
        ddr_ff[P4_IDX][P4_CLK_BIT] <= (mode_strap == MODE_1); // RQ12
      end
      for (int i = 0; i < IOPM_NUM_IO; i++) begin
        if (reg_wr && hit(reg_addr, OFS_DDR, i)) begin
          ddr_ff[i] <= reg_wdata & pmask(i); // RQ2
        end
      end
    end
  end

  // output data registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dr_ff <= {IOPM_NUM_IO{DR_RST}};
    end else begin
      for (int i = 0; i < IOPM_NUM_IO; i++) begin
        if (reg_wr && hit(reg_addr, OFS_DR, i)) begin
          dr_ff[i] <= reg_wdata & pmask(i); // RQ3
        end
      end
    end
  end

  // pull-up control, ports 1..3 only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcr_ff <= {IOPM_NUM_PU{PCR_RST}};
    end else begin
      for (int i = 0; i < IOPM_NUM_PU; i++) begin
        if (reg_wr && hit(reg_addr, OFS_PCR, i)) begin
          pcr_ff[i] <= reg_wdata; // RQ4
        end
      end
    end
  end

  // expansion control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= CFG_RST;
    end else if (reg_wr && reg_addr == OFS_CFG) begin
      cfg_ff <= reg_wdata[1:0]; // RQ13
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < IOPM_NUM_IO; i++) begin
      if (hit(reg_addr, OFS_DDR, i)) nxt_rdata = ddr_ff[i];
      if (hit(reg_addr, OFS_DR, i))  nxt_rdata = dr_ff[i];
    end
    for (int i = 0; i < IOPM_NUM_PU; i++) begin
      if (hit(reg_addr, OFS_PCR, i)) nxt_rdata = pcr_ff[i];
    end
    for (int i = 0; i < IOPM_NUM_PORT; i++) begin
      if (hit(reg_addr, OFS_PIN, i)) nxt_rdata = cfg.pin[i];
    end
    if (reg_addr == OFS_CFG)  nxt_rdata = {6'h00, cfg_ff};
    if (reg_addr == OFS_MODE) nxt_rdata = {6'h00, mode_ff};
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
  assign cfg.ddr   = ddr_ff;
  assign cfg.dr    = dr_ff;
  assign cfg.pullup_control_register   = pcr_ff;
  assign cfg.expansion_enable_bit  = cfg_ff[CFG_EXPANSION_ENABLE_BIT_BIT];
  assign cfg.p2io  = cfg_ff[CFG_P2IO_BIT];
  assign cfg.mode  = mode_ff;

endmodule
`default_nettype wire

/* rtl/iopm_top.sv */
// pin-function mux and direction control for ports 1..7
//
// What this block does
// [RQ1] six bidirectional ports plus one input-only port
// [RQ2] per-pin direction register on bidirectional ports
// [RQ3] output data register drives output pins
// [RQ4] ports one to three have pull-up control
// [RQ5] expanded port one, direction 0: input
// [RQ6] expanded port one, direction 1: address or PWM
// [RQ7] expanded port two output: address, PWM, serial, blanking
// [RQ8] expanded port two input: port, serial, blanking
// [RQ9] expanded upper port two usable as outputs
// [RQ10] single-chip port two: I/O, PWM, serial, I2C
// [RQ11] two port-four pins feed interrupts zero, one
// [RQ12] mode one clock pin outputs clock when set
// [RQ13] enable bit picks expanded or single-chip functions
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module iopm_top
  import iopm_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output var  logic [7:0]      reg_rdata,
  // operating mode strap
  input  wire logic [1:0]      mode_strap,
  // pins: index 0 is port 1, index 6 is port 7
  input  wire logic [6:0][7:0] pin_in,
  output var  logic [5:0][7:0] pin_out,
  output var  logic [5:0][7:0] pin_oe,
  output var  logic [2:0][7:0] pullup_en,
  // memory bus address
  input  wire logic [15:0]     ext_addr,
  // PWM timers
  input  wire logic [7:0]      pwm_out_low_group,
  input  wire logic [7:0]      pwm_low_en,
  input  wire logic [7:0]      pwm_out_high_group,
  input  wire logic [7:0]      pwm_high_en,
  input  wire logic            pwm_x_out_0,
  input  wire logic            pwm_x_out_1,
  input  wire logic [1:0]      pwm_x_en,
  // serial channel one
  input  wire logic            serial1_tx_data,
  input  wire logic            serial1_tx_en,
  input  wire logic            serial1_rx_en,
  input  wire logic            serial1_clk_out,
  input  wire logic            serial1_clk_oe,
  output var  logic            serial1_receive_pin,
  output var  logic            serial1_clock_pin,
  // timer connection
  input  wire logic            timer_blanking_output,
  input  wire logic            timer_blanking_en,
  // optional i2c channel one, open drain
  input  wire logic            i2c1_en,
  input  wire logic            i2c1_clk_drive_low,
  input  wire logic            i2c1_data_drive_low,
  output var  logic            i2c1_clock_pin,
  output var  logic            i2c1_data_pin,
  // interrupts and clocks
  output var  logic            ext_interrupt_in_0,
  output var  logic            ext_interrupt_in_1,
  input  wire logic            sysclk_src,
  output var  logic            external_sub_clock_input
);

  // ==========================================================
  // register file
  iopm_cfg_if cfg ();

  iopm_regs u_regs (
    .clk        (clk),
    .resetn     (resetn),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .mode_strap (mode_strap),
    .cfg        (cfg)
  );

  // port 7 has no direction or data register, only readback
  assign cfg.pin = pin_in; // RQ1

  // ==========================================================
  // pin function selection
  iopm_pinmode_t   pm;
  logic [5:0][7:0] nxt_out;
  logic [5:0][7:0] nxt_oe;
  logic [5:0][7:0] out_ff;
  logic [5:0][7:0] oe_ff;
  logic [2:0][7:0] pu_ff;

  assign pm = iopm_pin_mode(cfg.mode, cfg.expansion_enable_bit); // RQ13

  always_comb begin
    // plain I/O everywhere unless a function takes the pin over
    for (int i = 0; i < IOPM_NUM_IO; i++) begin
      nxt_out[i] = cfg.dr[i];  // RQ3
      nxt_oe[i]  = cfg.ddr[i]; // RQ2
    end

    unique case (pm)
      PM_MODE1: begin
        // address pins are driven whatever the direction bits say
        nxt_out[0] = ext_addr[7:0];
        nxt_oe[0]  = IOPM_FULL;
        nxt_out[1] = ext_addr[15:8];
        nxt_oe[1]  = IOPM_FULL;
      end
      PM_EXPAND: begin
        for (int b = 0; b < 8; b++) begin
          // direction 0 leaves the pin an input via nxt_oe
          nxt_out[0][b] = pwm_low_en[b] ? pwm_out_low_group[b]
                                        : ext_addr[b]; // RQ5 RQ6
        end
        for (int b = 0; b < 4; b++) begin
          nxt_out[1][b] = ext_addr[8 + b]; // RQ7
        end
        for (int b = 4; b < 8; b++) begin
          if (pwm_high_en[b]) begin
            nxt_out[1][b] = pwm_out_high_group[b]; // RQ7
          end else if (cfg.p2io) begin
            nxt_out[1][b] = cfg.dr[1][b]; // RQ9
          end else begin
            nxt_out[1][b] = ext_addr[8 + b]; // RQ7
          end
        end
      end
      PM_SINGLE: begin
        nxt_out[0] = (pwm_low_en & pwm_out_low_group)
                   | (~pwm_low_en & cfg.dr[0]);
        nxt_out[1] = (pwm_high_en & pwm_out_high_group)
                   | (~pwm_high_en & cfg.dr[1]); // RQ10
      end
    endcase

    if (pm != PM_MODE1) begin
      // pwm x channels take the two lowest port-one pins
      if (pwm_x_en[0]) nxt_out[0][P1_PWM_X_OUT_0_BIT] = pwm_x_out_0; // RQ6
      if (pwm_x_en[1]) nxt_out[0][P1_PWM_X_OUT_1_BIT] = pwm_x_out_1; // RQ6

      // serial and blanking override direction in either set
      if (serial1_tx_en) begin
        nxt_out[1][P2_TXD_BIT] = serial1_tx_data; // RQ8 RQ10
        nxt_oe[1][P2_TXD_BIT]  = 1'b1;
      end
      if (serial1_rx_en) begin
        nxt_oe[1][P2_RXD_BIT]  = 1'b0; // RQ8
      end
      if (serial1_clk_oe) begin
        nxt_out[1][P2_SCK_BIT] = serial1_clk_out; // RQ7
        nxt_oe[1][P2_SCK_BIT]  = 1'b1;
      end else if (timer_blanking_en) begin
        nxt_out[1][P2_SCK_BIT] = timer_blanking_output; // RQ8
        nxt_oe[1][P2_SCK_BIT]  = 1'b1;
      end
    end

    // i2c exists only in single-chip mode; only ever pulls low
    if (pm == PM_SINGLE && i2c1_en) begin
      nxt_out[1][P2_SCL_BIT] = 1'b0; // RQ10
      nxt_oe[1][P2_SCL_BIT]  = i2c1_clk_drive_low;
      nxt_out[1][P2_SDA_BIT] = 1'b0;
      nxt_oe[1][P2_SDA_BIT]  = i2c1_data_drive_low;
    end

    // clock pin: system clock out while its direction bit is set
    if (cfg.ddr[P4_IDX][P4_CLK_BIT]) begin
      nxt_out[P4_IDX][P4_CLK_BIT] = sysclk_src; // RQ12
    end
  end

  // ==========================================================
  // registered pin drivers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_ff <= {IOPM_NUM_IO{DR_RST}};
      oe_ff  <= {IOPM_NUM_IO{DDR_RST}};
    end else begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
    end
  end

  // pull-ups only on pins not being driven, saves static current
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pu_ff <= {IOPM_NUM_PU{PCR_RST}};
    end else begin
      for (int i = 0; i < IOPM_NUM_PU; i++) begin
        pu_ff[i] <= cfg.pullup_control_register[i] & ~nxt_oe[i]; // RQ4
      end
    end
  end

  assign pin_out   = out_ff;
  assign pin_oe    = oe_ff;
  assign pullup_en = pu_ff;

  // ==========================================================
  // pin levels returned to the peripherals
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_interrupt_in_0 <= 1'b0;
      ext_interrupt_in_1 <= 1'b0;
    end else begin
      // interrupt taps stay live in every mode, pin stays I/O
      ext_interrupt_in_0 <= pin_in[P4_IDX][P4_EXT_INTERRUPT_IN_0_BIT]; // RQ11
      ext_interrupt_in_1 <= pin_in[P4_IDX][P4_EXT_INTERRUPT_IN_1_BIT]; // RQ11
    end
  end

  // external clock is only passed on while the pin is an input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      external_sub_clock_input <= 1'b0;
    end else begin
      external_sub_clock_input <= ~cfg.ddr[P4_IDX][P4_CLK_BIT]
                                & pin_in[P4_IDX][P4_CLK_BIT]; // RQ12
    end
  end

  // serial and i2c receive taps; idle high when not owned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial1_receive_pin <= 1'b1;
      serial1_clock_pin   <= 1'b1;
      i2c1_clock_pin      <= 1'b1;
      i2c1_data_pin       <= 1'b1;
    end else begin
      serial1_receive_pin <= (pm == PM_MODE1) | pin_in[1][P2_RXD_BIT];
      serial1_clock_pin   <= (pm == PM_MODE1) | pin_in[1][P2_SCK_BIT];
      i2c1_clock_pin      <= (pm != PM_SINGLE) | pin_in[1][P2_SCL_BIT];
      i2c1_data_pin       <= (pm != PM_SINGLE) | pin_in[1][P2_SDA_BIT];
    end
  end

endmodule
`default_nettype wire

/* sim/iopm_sva.sv */
// assertion checker for the port pin-function mux
`timescale 1ns/10ps
`default_nettype none
module iopm_sva
  import iopm_pkg::*;
(
  // clock and reset
  input wire logic            clk,
  input wire logic            resetn,
  // register port and strap
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic [1:0]      mode_strap,
  // pins and taps
  input wire logic [6:0][7:0] pin_in,
  input wire logic [5:0][7:0] pin_out,
  input wire logic [5:0][7:0] pin_oe,
  input wire logic [2:0][7:0] pullup_en,
  input wire logic [15:0]     ext_addr,
  input wire logic            serial1_tx_data,
  input wire logic            serial1_tx_en,
  input wire logic            serial1_rx_en,
  input wire logic            sysclk_src,
  input wire logic            ext_interrupt_in_0,
  input wire logic            ext_interrupt_in_1,
  input wire logic            external_sub_clock_input
);
  // ==========================================================
  // settle counter: mode capture plus one mux flop after reset
  logic [1:0] up_ff;
  logic       armed;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  assign armed = (up_ff == 2'h3);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // properties
  sequence s_m1_addr;
    ##1 pin_out[0] == $past(ext_addr[7:0]) &&
        pin_out[1] == $past(ext_addr[15:8]);
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  pullup_off_a: assert property ((pullup_en & pin_oe[2:0]) == 24'h0)
    else $error("pull-up on a driven pin");
  irq_zero_a: assert property (armed |->
    ext_interrupt_in_0 == $past(pin_in[3][2]))
    else $error("interrupt zero tap wrong");
  irq_one_a: assert property (armed |->
    ext_interrupt_in_1 == $past(pin_in[3][1]))
    else $error("interrupt one tap wrong");
  mode1_addr_a: assert property (
    armed && mode_strap == 2'h1 |-> s_m1_addr)
    else $error("mode one address not on ports");
  mode1_oe_a: assert property (armed && mode_strap == 2'h1 |->
    pin_oe[1:0] == 16'hFFFF)
    else $error("mode one address pins not driven");
  rx_input_a: assert property (armed && mode_strap != 2'h1 &&
    serial1_rx_en |=> !pin_oe[1][6])
    else $error("receive pin driven");
  tx_drive_a: assert property (armed && mode_strap != 2'h1 &&
    serial1_tx_en |=> pin_oe[1][5] && pin_out[1][5] == $past(serial1_tx_data))
    else $error("transmit pin not driven");
  clk_out_a: assert property (armed && pin_oe[3][6] |->
    pin_out[3][6] == $past(sysclk_src) && !external_sub_clock_input)
    else $error("clock pin output wrong");
endmodule

bind iopm_top iopm_sva iopm_sva_inst (.clk, .resetn, .reg_rd, .reg_rdata,
  .mode_strap, .pin_in, .pin_out, .pin_oe, .pullup_en, .ext_addr,
  .serial1_tx_data, .serial1_tx_en, .serial1_rx_en, .sysclk_src,
  .ext_interrupt_in_0, .ext_interrupt_in_1, .external_sub_clock_input);
`default_nettype wire

/* sim/iopm_pin_model.sv */
// board-side model of the port pins
`timescale 1ns/10ps
`default_nettype none
module iopm_pin_model (
  // clock
  input  wire logic            clk,
  // device side
  input  wire logic [5:0][7:0] pin_out,
  input  wire logic [5:0][7:0] pin_oe,
  input  wire logic [2:0][7:0] pullup_en,
  // far-side drivers
  input  wire logic [6:0][7:0] ext_drv,
  input  wire logic [6:0][7:0] ext_oe,
  output var  logic [6:0][7:0] pin_in
);
  logic            float_ff;
  logic [6:0][7:0] oe7;
  logic [6:0][7:0] pu7;

  // a floating pin toggles so stale data never reads as a match
  always @(posedge clk) begin
    float_ff <= (float_ff === 1'b1) ? 1'b0 : 1'b1;
  end

  // wire level: device drive, then board drive, then pull-up
  assign oe7 = {8'h00, pin_oe};
  assign pu7 = {32'h0, pullup_en};
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (oe7[p][b]) pin_in[p][b] = oe7[p][b] & pin_out[p % 6][b];
        else if (ext_oe[p][b]) pin_in[p][b] = ext_drv[p][b];
        else if (pu7[p][b]) pin_in[p][b] = 1'b1;
        else pin_in[p][b] = float_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking testbench for the port pin-function mux
`timescale 1ns/10ps
`default_nettype none
module testbench
  import iopm_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] mode_strap = 2'h2, pwm_x_en = 2'h0;
  logic [6:0][7:0] pin_in, ext_drv = '0, ext_oe = '0;
  logic [5:0][7:0] pin_out, pin_oe;
  logic [2:0][7:0] pullup_en;
  logic [15:0] ext_addr = 16'hC671;
  logic [7:0] pwm_out_low_group = 8'h00, pwm_low_en = 8'h00;
  logic [7:0] pwm_out_high_group = 8'h00, pwm_high_en = 8'h00;
  logic pwm_x_out_0 = 1'b0, pwm_x_out_1 = 1'b0, serial1_tx_data = 1'b0;
  logic serial1_tx_en = 1'b0, serial1_rx_en = 1'b0, serial1_clk_out = 1'b0;
  logic serial1_clk_oe = 1'b0, timer_blanking_output = 1'b0;
  logic timer_blanking_en = 1'b0, i2c1_en = 1'b0, i2c1_clk_drive_low = 1'b0;
  logic i2c1_data_drive_low = 1'b0, sysclk_src = 1'b0;
  logic serial1_receive_pin, serial1_clock_pin, i2c1_clock_pin;
  logic i2c1_data_pin, ext_interrupt_in_0, ext_interrupt_in_1;
  logic external_sub_clock_input;
  int   n_errors = 0;
  int   n_tests = 0;

  // ==========================================================
  // clock, system clock source and instances
  always #25 clk = ~clk;
  always @(posedge clk) sysclk_src <= ~sysclk_src;

  iopm_top iopm_top_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mode_strap, .pin_in, .pin_out, .pin_oe,
    .pullup_en, .ext_addr, .pwm_out_low_group, .pwm_low_en,
    .pwm_out_high_group, .pwm_high_en, .pwm_x_out_0, .pwm_x_out_1,
    .pwm_x_en, .serial1_tx_data, .serial1_tx_en, .serial1_rx_en,
    .serial1_clk_out, .serial1_clk_oe, .serial1_receive_pin,
    .serial1_clock_pin, .timer_blanking_output, .timer_blanking_en,
    .i2c1_en, .i2c1_clk_drive_low, .i2c1_data_drive_low, .i2c1_clock_pin,
    .i2c1_data_pin, .ext_interrupt_in_0, .ext_interrupt_in_1, .sysclk_src,
    .external_sub_clock_input);
  iopm_pin_model iopm_pin_model_inst (.clk, .pin_out, .pin_oe, .pullup_en,
    .ext_drv, .ext_oe, .pin_in);

  // ==========================================================
  // bus tasks and checks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk);
    resetn <= 1'b0;
    mode_strap <= m;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial begin
    do_reset(2'h2);
    for (int i = 0; i < 6; i++) begin
      rd(OFS_DDR + 8'(i), 8'h00);
      rd(OFS_DR + 8'(i), 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      rd(OFS_PCR + 8'(i), 8'h00);
    end
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h00);
    // single-chip functions on ports one and two
    wr(OFS_DDR, 8'hFF);
    wr(OFS_DR, 8'h3C);
    wr(OFS_DDR + 8'h01, 8'hFF);
    wr(OFS_DR + 8'h01, 8'hC3);
    wr(OFS_PCR + 8'h01, 8'h10);
    pwm_low_en <= 8'h0F;
    pwm_out_low_group <= 8'h05;
    pwm_x_en <= 2'h3;
    pwm_x_out_1 <= 1'b1;
    pwm_high_en <= 8'hF0;
    pwm_out_high_group <= 8'hA0;
    i2c1_en <= 1'b1;
    i2c1_data_drive_low <= 1'b1;
    ext_oe <= 56'hFF000046004000;
    ext_drv <= 56'h5A000044004000;
    settle();
    chk(pin_out[0], 8'h36);
    chk(pin_oe[0], 8'hFF);
    chk(pin_out[1], 8'hA3);
    chk(pin_oe[1], 8'hEF);
    chk(pullup_en[1], 8'h10);
    chk({7'h0, i2c1_clock_pin}, 8'h01);
    chk({7'h0, i2c1_data_pin}, 8'h00);
    chk({6'h0, ext_interrupt_in_1, ext_interrupt_in_0}, 8'h01);
    chk({7'h0, external_sub_clock_input}, 8'h01);
    rd(OFS_PIN + 8'h06, 8'h5A);
    // expanded functions
    wr(OFS_CFG, 8'h01);
    pwm_low_en <= 8'h00;
    pwm_x_en <= 2'h0;
    pwm_high_en <= 8'h00;
    ext_addr <= 16'h5E71;
    settle();
    chk(pin_out[0], 8'h71);
    chk(pin_out[1], 8'h5E);
    chk(pin_oe[1], 8'hFF);
    chk({7'h0, i2c1_data_pin}, 8'h01);
    wr(OFS_CFG, 8'h03);
    wr(OFS_DDR, 8'h0F);
    serial1_rx_en <= 1'b1;
    serial1_tx_en <= 1'b1;
    serial1_tx_data <= 1'b1;
    timer_blanking_en <= 1'b1;
    settle();
    chk(pin_out[1] & 8'hBF, 8'h2E);
    chk(pin_oe[1], 8'hBF);
    chk(pin_oe[0], 8'h0F);
    chk({7'h0, serial1_receive_pin}, 8'h01);
    chk({7'h0, serial1_clock_pin}, 8'h00);
    wr(OFS_CFG, 8'h00);
    settle();
    chk(pin_out[0], 8'h3C);
    // mode one: clock pin output out of reset
    do_reset(2'h1);
    rd(OFS_DDR + 8'h03, 8'h40);
    settle();
    chk(pin_oe[0], 8'hFF);
    chk(pin_out[1], 8'h5E);
    wr(OFS_DDR + 8'h03, 8'h00);
    settle();
    chk({7'h0, external_sub_clock_input}, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
